// file: core/eic_top.v
// Purpose: conditions three external request inputs and keeps their flags
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   read data are captured in the address phase
`timescale 1ns/10ps
`include "eic_defines.vh"
module eic_top
#(
  parameter ADDR_W = 12
)
(
  // clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire              hwrite,
  input  wire [1:0]        htrans,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  // external pins
  input  wire              pin_a,
  input  wire              pin_b_first,
  input  wire              pin_b_second,
  input  wire              pin_c,
  input  wire              slow_internal_clock,
  // timer c count source
  input  wire              timer_c_count_tick,
  // cpu acknowledge
  input  wire              ack_a,
  input  wire              ack_b,
  input  wire              ack_c,
  // request flags and raw pin level
  output reg               request_flag_a,
  output reg               request_flag_b,
  output reg               request_flag_c,
  output reg               shared_pin_raw_level
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [1:0]  filt_a_q;
  reg  [7:0]  timer_x_mode_q;
  reg  [1:0]  inen_q;
  reg  [7:0]  tcc_lo_q;
  reg  [7:0]  tcc_hi_q;
  reg         pol_a_q;
  reg         pin_sel_q;
  reg         wr_pend_q;
  reg  [9:0]  wr_idx_q;
  reg         pend_c_q;
  wire [4:0]  pin_vec;
  wire [4:0]  sync_lvl;
  reg         prev_a_q;
  reg         prev_b_q;
  reg         prev_c_q;
  reg  [31:0] rd_d;

  wire [9:0]  addr_idx;
  wire        acc;
  wire        wr_now;
  wire [7:0]  wb;
  wire        f1_en;
  wire        f8_en;
  wire        f32_en;
  wire        lvl_a;
  wire        lvl_c;
  wire        samp_a;
  wire        samp_c;
  wire        filt_a_on;
  wire        filt_c_on;
  wire        src_c;
  wire        raw_b;
  wire        rise_a;
  wire        fall_a;
  wire        rise_b;
  wire        fall_b;
  wire        rise_c;
  wire        fall_c;
  wire        evt_a;
  wire        evt_b;
  wire        evt_c;
  wire        now_c;
  wire        set_a;
  wire        set_b;
  wire        set_c;
  wire        rewr_a;
  wire        rewr_b;
  wire        rewr_c;
  wire        clr_a;
  wire        clr_b;
  wire        clr_c;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // zero wait states, so the address phase is never stretched
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_idx  = haddr[11:2];
  assign acc       = hsel & htrans[1] & hready;
  assign wr_now    = wr_pend_q;
  assign wb        = hwdata[7:0];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 10'h000;
    end
    else
    begin
      wr_pend_q <= acc & hwrite;
      if (acc & hwrite)
        wr_idx_q <= addr_idx;
    end
  end

  // unmapped addresses read zero and ignore writes
  always @*
  begin
    rd_d = 32'h00000000;
    case (addr_idx)
      `EIC_IDX_FILT_A: rd_d[1:0] = filt_a_q;
      `EIC_IDX_TIMER_X_MODE:   rd_d[7:0] = timer_x_mode_q;
      `EIC_IDX_INEN:   rd_d[1:0] = inen_q;
      `EIC_IDX_TCC_LO: rd_d[7:0] = tcc_lo_q;
      `EIC_IDX_TCC_HI: rd_d[7:0] = tcc_hi_q;
      `EIC_IDX_CTL_A:
      begin
        rd_d[`EIC_CTL_FLAG] = request_flag_a;
        rd_d[`EIC_CTL_POL]  = pol_a_q;
      end
      `EIC_IDX_CTL_B:  rd_d[`EIC_CTL_FLAG] = request_flag_b;
      `EIC_IDX_CTL_C:  rd_d[`EIC_CTL_FLAG] = request_flag_c;
      `EIC_IDX_SERIAL: rd_d[`EIC_SER_PINSEL] = pin_sel_q;
      default:         rd_d = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (acc & ~hwrite)
      hrdata <= rd_d;
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // unused bits of filt_a_q, inen_q and bit 5 of tcc_lo_q are kept at zero; timer_x_mode_q and tcc_hi_q store all eight bits
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_a_q  <= 2'b00;
      timer_x_mode_q    <= `EIC_RST_BYTE;
      inen_q    <= 2'b00;
      tcc_lo_q  <= `EIC_RST_BYTE;
      tcc_hi_q  <= `EIC_RST_BYTE;
      pol_a_q   <= 1'b0;
      pin_sel_q <= 1'b0;
    end
    else if (wr_now)
    begin
      case (wr_idx_q)
        `EIC_IDX_FILT_A: filt_a_q  <= wb[1:0];
        `EIC_IDX_TIMER_X_MODE:   timer_x_mode_q    <= wb;
        `EIC_IDX_INEN:   inen_q    <= wb[1:0];
        `EIC_IDX_TCC_LO: tcc_lo_q  <= {wb[7:6], 1'b0, wb[4:0]};
        `EIC_IDX_TCC_HI: tcc_hi_q  <= wb;
        `EIC_IDX_CTL_A:  pol_a_q   <= wb[`EIC_CTL_POL];
        `EIC_IDX_SERIAL: pin_sel_q <= wb[`EIC_SER_PINSEL];
        default:         pin_sel_q <= pin_sel_q;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // each stage keeps its own flops, so no vector has several drivers
  assign pin_vec = {slow_internal_clock, pin_c, pin_b_second, pin_b_first, pin_a};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      reg s1_q;
      reg s2_q;
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end
        else
        begin
          s1_q <= pin_vec[gi];
          s2_q <= s1_q;
        end
      end
      assign sync_lvl[gi] = s2_q;
    end
  endgenerate

  // raw level skips the filter so software always sees the pin
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      shared_pin_raw_level <= 1'b0;
    else
      shared_pin_raw_level <= sync_lvl[3];
  end

  // ----------------------------------------
  // sampling clocks and filters
  // ----------------------------------------
  eic_divider u_div
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .f1_en   (f1_en),
    .f8_en   (f8_en),
    .f32_en  (f32_en)
  );

  assign filt_a_on = (filt_a_q != 2'b00);
  assign samp_a    = (filt_a_q == 2'b01) ? f1_en :
                     (filt_a_q == 2'b10) ? f8_en : f32_en;
  assign filt_c_on = (tcc_hi_q[1:0] != 2'b00);
  assign samp_c    = (tcc_hi_q[1:0] == 2'b01) ? f1_en :
                     (tcc_hi_q[1:0] == 2'b10) ? f8_en : f32_en;
  assign src_c     = tcc_lo_q[`EIC_TCC_SOURCE] ? sync_lvl[4] : sync_lvl[3];

  eic_filter u_filt_a
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .filter_on (filt_a_on),
    .sample_en (samp_a),
    .din       (sync_lvl[0]),
    .level_q   (lvl_a)
  );

  eic_filter u_filt_c
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .filter_on (filt_c_on),
    .sample_en (samp_c),
    .din       (src_c),
    .level_q   (lvl_c)
  );

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  assign raw_b = pin_sel_q ? sync_lvl[2] : sync_lvl[1];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
      prev_c_q <= 1'b0;
    end
    else
    begin
      prev_a_q <= lvl_a;
      prev_b_q <= raw_b;
      prev_c_q <= lvl_c;
    end
  end

  assign rise_a = lvl_a & ~prev_a_q;
  assign fall_a = ~lvl_a & prev_a_q;
  assign rise_b = raw_b & ~prev_b_q;
  assign fall_b = ~raw_b & prev_b_q;
  assign rise_c = lvl_c & ~prev_c_q;
  assign fall_c = ~lvl_c & prev_c_q;

  assign evt_a = inen_q[`EIC_INEN_EN] &
                 (inen_q[`EIC_INEN_BOTH] ? (rise_a | fall_a) :
                  (pol_a_q ? rise_a : fall_a));

  assign evt_b = timer_x_mode_q[`EIC_TIMER_X_MODE_POL] ? fall_b : rise_b;

  // with the slow clock as source, one or both edges give once or twice
  // per slow cycle
  assign evt_c = (tcc_lo_q[4:3] == 2'b00) ? rise_c :
                 (tcc_lo_q[4:3] == 2'b01) ? fall_c :
                 (tcc_lo_q[4:3] == 2'b10) ? (rise_c | fall_c) :
                 1'b0;

  // ----------------------------------------
  // request timing for input c
  // ----------------------------------------
  // filter output already moves on the sampling clock, so it goes at once
  assign now_c = tcc_lo_q[`EIC_TCC_TIMING] | filt_c_on |
                 tcc_hi_q[`EIC_TCC_CMP];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_c_q <= 1'b0;
    else if (now_c)
      pend_c_q <= 1'b0;
    else if (evt_c)
      pend_c_q <= 1'b1;
    else if (timer_c_count_tick)
      pend_c_q <= 1'b0;
  end

  // ----------------------------------------
  // request flags
  // ----------------------------------------
  // a write that changes an edge choice counts as an event, as the
  // detector cannot tell old from new setting
  assign rewr_a = wr_now &
                  (((wr_idx_q == `EIC_IDX_INEN) &
                    (wb[`EIC_INEN_BOTH] != inen_q[`EIC_INEN_BOTH])) |
                   ((wr_idx_q == `EIC_IDX_CTL_A) &
                    (wb[`EIC_CTL_POL] != pol_a_q)));
  assign rewr_b = wr_now & (wr_idx_q == `EIC_IDX_TIMER_X_MODE) &
                  (wb[`EIC_TIMER_X_MODE_POL] != timer_x_mode_q[`EIC_TIMER_X_MODE_POL]);
  assign rewr_c = wr_now & (wr_idx_q == `EIC_IDX_TCC_LO) &
                  ((wb[7:6] != tcc_lo_q[7:6]) |
                   (wb[4:3] != tcc_lo_q[4:3]));

  assign set_a = evt_a | rewr_a;
  assign set_b = evt_b | rewr_b;
  assign set_c = (evt_c & now_c) | (pend_c_q & timer_c_count_tick) |
                 rewr_c;

  // writing one is ignored, writing zero clears
  assign clr_a = ack_a | (wr_now & (wr_idx_q == `EIC_IDX_CTL_A) &
                 ~wb[`EIC_CTL_FLAG]);
  assign clr_b = ack_b | (wr_now & (wr_idx_q == `EIC_IDX_CTL_B) &
                 ~wb[`EIC_CTL_FLAG]);
  assign clr_c = ack_c | (wr_now & (wr_idx_q == `EIC_IDX_CTL_C) &
                 ~wb[`EIC_CTL_FLAG]);

  // a new request in the clearing cycle must not be lost
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      request_flag_a <= 1'b0;
      request_flag_b <= 1'b0;
      request_flag_c <= 1'b0;
    end
    else
    begin
      if (set_a)
        request_flag_a <= 1'b1;
      else if (clr_a)
        request_flag_a <= 1'b0;
      if (set_b)
        request_flag_b <= 1'b1;
      else if (clr_b)
        request_flag_b <= 1'b0;
      if (set_c)
        request_flag_c <= 1'b1;
      else if (clr_c)
        request_flag_c <= 1'b0;
    end
  end
endmodule

// file: core/eic_defines.vh
// Purpose: constants of the external request conditioning block
// Assumes: register indices are kept, byte address is four times index
// Notes:   field positions are bit numbers within the low byte
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define EIC_IDX_FILT_A   10'h01e
`define EIC_IDX_TIMER_X_MODE     10'h08b
`define EIC_IDX_INEN     10'h096
`define EIC_IDX_TCC_LO   10'h09a
`define EIC_IDX_TCC_HI   10'h09b
`define EIC_IDX_CTL_A    10'h040
`define EIC_IDX_CTL_B    10'h041
`define EIC_IDX_CTL_C    10'h042
`define EIC_IDX_SERIAL   10'h060
// ----------------------------------------
// field positions
// ----------------------------------------
`define EIC_INEN_EN      0
`define EIC_INEN_BOTH    1
`define EIC_TIMER_X_MODE_POL     2
`define EIC_TCC_RUN      0
`define EIC_TCC_POL_LO   3
`define EIC_TCC_POL_HI   4
`define EIC_TCC_TIMING   6
`define EIC_TCC_SOURCE   7
`define EIC_TCC_CMP      3
`define EIC_CTL_FLAG     0
`define EIC_CTL_POL      4
`define EIC_SER_PINSEL   0
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define EIC_RST_BYTE     8'h00
`define EIC_DIV_F8       3'h7
`define EIC_DIV_F32      5'h1f
`define EIC_MATCH_COUNT  3
`endif

// file: core/eic_divider.v
// Purpose: sampling enables f1, f8 and f32 from the system clock
// Assumes: one clock domain
// Notes:   f8 and f32 are one-cycle pulses, f1 is always high
`timescale 1ns/10ps
`include "eic_defines.vh"
module eic_divider
(
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // enables
  output wire       f1_en,
  output wire       f8_en,
  output wire       f32_en
);
  reg  [4:0] cnt_q;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= 5'h00;
    else
      cnt_q <= cnt_q + 5'h01;
  end

  assign f1_en  = 1'b1;
  assign f8_en  = (cnt_q[2:0] == `EIC_DIV_F8);
  assign f32_en = (cnt_q == `EIC_DIV_F32);
endmodule

// file: core/eic_filter.v
// Purpose: digital majority-free agreement filter for one request input
// Assumes: din already synchronised to hclk
// Notes:   with filter off the level follows every sample
`timescale 1ns/10ps
`include "eic_defines.vh"
module eic_filter
#(
  parameter MATCH = `EIC_MATCH_COUNT
)
(
  // clock and reset
  input  wire hclk,
  input  wire hresetn,
  // control
  input  wire filter_on,
  input  wire sample_en,
  // data
  input  wire din,
  output reg  level_q
);
  reg  [MATCH-1:0] hist_q;
  wire [MATCH-1:0] hist_d;

  assign hist_d = {hist_q[MATCH-2:0], din};

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hist_q  <= {MATCH{1'b0}};
      level_q <= 1'b0;
    end
    else if (!filter_on)
    begin
      hist_q  <= {MATCH{din}};
      level_q <= din;
    end
    else if (sample_en)
    begin
      hist_q <= hist_d;
      if (hist_d == {MATCH{1'b1}})
        level_q <= 1'b1;
      else if (hist_d == {MATCH{1'b0}})
        level_q <= 1'b0;
    end
  end
endmodule

// file: tb/eic_assertions.sv
// Purpose: port checks for the request conditioning block
// Assumes: sees eic_top ports only
// Notes:   a falling flag is traced back to an ack or a bus write
`timescale 1ns/10ps
`include "eic_defines.vh"
module eic_assertions
#(
  parameter ADDR_W = 12
)
(
  // clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // bus
  input  wire              hsel,
  input  wire [ADDR_W-1:0] haddr,
  input  wire              hwrite,
  input  wire [1:0]        htrans,
  input  wire              hready,
  input  wire              hreadyout,
  input  wire              hresp,
  input  wire [31:0]       hrdata,
  // pins, acks and flags
  input  wire              pin_c,
  input  wire              ack_a,
  input  wire              ack_b,
  input  wire              ack_c,
  input  wire              request_flag_a,
  input  wire              request_flag_b,
  input  wire              request_flag_c,
  input  wire              shared_pin_raw_level
);
  wire       take_w = hsel & htrans[1] & hready & hwrite;
  wire       take_r = hsel & htrans[1] & hready & ~hwrite;
  wire [9:0] idx    = haddr[ADDR_W-1:2];
  // ------
  // properties
  // ------
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  rdata_hold_a: assert property (!take_r |=> $stable(hrdata))
    else $error("read data moved without a read");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  raw_level_a: assert property ($past(hresetn, 3) && $past(hresetn, 2) && $past(hresetn)
    |-> shared_pin_raw_level == $past(pin_c, 3))
    else $error("raw pin level wrong");
  clear_a_a: assert property ($fell(request_flag_a)
    |-> $past(ack_a) || $past(take_w && idx == `EIC_IDX_CTL_A, 2))
    else $error("flag a cleared without cause");
  clear_b_a: assert property ($fell(request_flag_b)
    |-> $past(ack_b) || $past(take_w && idx == `EIC_IDX_CTL_B, 2))
    else $error("flag b cleared without cause");
  clear_c_a: assert property ($fell(request_flag_c)
    |-> $past(ack_c) || $past(take_w && idx == `EIC_IDX_CTL_C, 2))
    else $error("flag c cleared without cause");
  flags_reset_a: assert property ($rose(hresetn)
    |-> !request_flag_a && !request_flag_b && !request_flag_c)
    else $error("flag set after reset");
endmodule

// file: tb/eic_partner.sv
// Purpose: cpu acknowledge and slow clock source facing the block
// Assumes: one hclk domain
// Notes:   acks only while told to, slow clock stands still when off
`timescale 1ns/10ps
module eic_partner
(
  // clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // bench control
  input  wire       ack_on,
  input  wire       slow_run,
  // flags and answers
  input  wire [2:0] flags,
  output reg  [2:0] acks,
  output reg        slow_clk
);
  reg [2:0] cnt_q;
  // ------
  // acknowledge and slow clock
  // ------
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      acks     <= 3'h0;
      slow_clk <= 1'b0;
      cnt_q    <= 3'h0;
    end
    else
    begin
      acks  <= ack_on ? (flags & ~acks) : 3'h0;
      cnt_q <= slow_run ? cnt_q + 3'h1 : 3'h0;
      if (slow_run && cnt_q == 3'h7)
        slow_clk <= ~slow_clk;
    end
endmodule

// file: tb/eic_top_tb.sv
// Purpose: self-checking bench for the request conditioning block
// Assumes: zero wait bus, ack from partner model
// Notes:   flags cleared by ack after each wait
`timescale 1ns/10ps
`include "eic_defines.vh"
module eic_top_tb;
  reg         hclk, hresetn, hsel, hwrite, tick, ack_on, slow_run;
  reg  [11:0] haddr;
  reg  [1:0]  htrans;
  reg  [31:0] hwdata, rd;
  reg  [3:0]  pins;
  reg  [25:0] rows [0:5];
  wire        hready, hresp, raw, slow_clk;
  wire [31:0] hrdata;
  wire [2:0]  flags, acks;
  integer     bad_count, checks, i, k, dv;
  eic_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .hwrite(hwrite), .htrans(htrans), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .pin_a(pins[0]),
    .pin_b_first(pins[1]), .pin_b_second(pins[2]), .pin_c(pins[3]),
    .slow_internal_clock(slow_clk), .timer_c_count_tick(tick), .ack_a(acks[0]),
    .ack_b(acks[1]), .ack_c(acks[2]), .request_flag_a(flags[0]),
    .request_flag_b(flags[1]), .request_flag_c(flags[2]), .shared_pin_raw_level(raw));
  eic_partner u_far (.hclk(hclk), .hresetn(hresetn), .ack_on(ack_on),
    .slow_run(slow_run), .flags(flags), .acks(acks), .slow_clk(slow_clk));
  // ------
  // tasks
  // ------
  task check(input [31:0] seen, input [31:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task rdy;
    integer n;
  begin
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n = n + 1;
      if (n > 50)
      begin
        bad_count = bad_count + 1;
        print_verdict;
      end
      @(posedge hclk);
    end
  end
  endtask
  task xfer(input w, input [9:0] idx, input [7:0] d);
  begin
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {idx, 2'b00};
    rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    rdy;
    rd = hrdata;
  end
  endtask
  task ack_all;
  begin
    ack_on <= 1'b1;
    repeat (4) @(posedge hclk);
    ack_on <= 1'b0;
    @(posedge hclk);
    check(flags, 3'h0);
  end
  endtask
  // bounded wait for a flag, then acknowledge
  task wf(input integer f, input e, input integer n);
    integer j;
    reg     hit;
  begin
    hit = 1'b0;
    for (j = 0; j < n && !hit; j = j + 1)
    begin
      @(posedge hclk);
      hit = flags[f] === 1'b1;
    end
    check(hit, e);
    ack_all;
  end
  endtask
  // ------
  // stimulus
  // ------
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, tick, ack_on, slow_run} = 6'h0;
    {haddr, htrans, hwdata, pins} = 50'h0;
    bad_count = 0;
    checks = 0;
    rows[0] = {`EIC_IDX_FILT_A, 8'hff, 8'h03};
    rows[1] = {`EIC_IDX_TIMER_X_MODE, 8'hff, 8'hff};
    rows[2] = {`EIC_IDX_INEN, 8'hff, 8'h03};
    rows[3] = {`EIC_IDX_TCC_LO, 8'hfe, 8'hde};
    rows[4] = {`EIC_IDX_TCC_HI, 8'hff, 8'hff};
    rows[5] = {10'h3ff, 8'hff, 8'h00};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(flags, 3'h0);
    for (i = 0; i < 6; i = i + 1)
    begin
      xfer(1'b0, rows[i][25:16], 8'h00);
      check(rd, 32'h0);
      xfer(1'b1, rows[i][25:16], rows[i][15:8]);
      xfer(1'b0, rows[i][25:16], 8'h00);
      check(rd, {24'h0, rows[i][7:0]});
      xfer(1'b1, rows[i][25:16], 8'h00);
    end
    ack_all;
    $display("test registers done");
    xfer(1'b1, `EIC_IDX_CTL_A, 8'h10);
    xfer(1'b1, `EIC_IDX_CTL_A, 8'h10);
    pins[0] <= 1'b1;
    wf(0, 1'b0, 20);
    pins[0] <= 1'b0;
    xfer(1'b1, `EIC_IDX_INEN, 8'h01);
    pins[0] <= 1'b1;
    wf(0, 1'b1, 20);
    pins[0] <= 1'b0;
    wf(0, 1'b0, 20);
    xfer(1'b1, `EIC_IDX_INEN, 8'h03);
    xfer(1'b1, `EIC_IDX_CTL_A, 8'h00);
    wf(0, 1'b1, 4);
    pins[0] <= 1'b1;
    wf(0, 1'b1, 20);
    pins[0] <= 1'b0;
    wf(0, 1'b1, 20);
    for (k = 1; k < 4; k = k + 1)
    begin
      dv = k == 1 ? 1 : k == 2 ? 8 : 32;
      xfer(1'b1, `EIC_IDX_FILT_A, k[7:0]);
      ack_all;
      pins[0] <= 1'b1;
      repeat (2 * dv) @(posedge hclk);
      pins[0] <= 1'b0;
      wf(0, 1'b0, 6 * dv + 8);
      pins[0] <= 1'b1;
      wf(0, 1'b1, 4 * dv + 8);
      pins[0] <= 1'b0;
      wf(0, 1'b1, 4 * dv + 8);
    end
    $display("test input a done");
    pins[2] <= 1'b1;
    wf(1, 1'b0, 20);
    pins[1] <= 1'b1;
    wf(1, 1'b1, 20);
    pins[1] <= 1'b0;
    wf(1, 1'b0, 20);
    xfer(1'b1, `EIC_IDX_TIMER_X_MODE, 8'h04);
    wf(1, 1'b1, 4);
    xfer(1'b1, `EIC_IDX_SERIAL, 8'h01);
    ack_all;
    pins[1] <= 1'b1;
    wf(1, 1'b0, 20);
    pins[1] <= 1'b0;
    wf(1, 1'b0, 20);
    pins[2] <= 1'b0;
    wf(1, 1'b1, 20);
    $display("test input b done");
    for (k = 0; k < 4; k = k + 1)
    begin
      xfer(1'b1, `EIC_IDX_TCC_LO, {3'h2, k[1:0], 3'h0});
      ack_all;
      pins[3] <= 1'b1;
      wf(2, k == 0 || k == 2, 20);
      check(raw, 1'b1);
      pins[3] <= 1'b0;
      wf(2, k == 1 || k == 2, 20);
    end
    xfer(1'b1, `EIC_IDX_TCC_LO, 8'h00);
    wf(2, 1'b1, 4);
    pins[3] <= 1'b1;
    wf(2, 1'b0, 20);
    tick <= 1'b1;
    @(posedge hclk);
    tick <= 1'b0;
    wf(2, 1'b1, 4);
    pins[3] <= 1'b0;
    xfer(1'b1, `EIC_IDX_TCC_HI, 8'h08);
    ack_all;
    pins[3] <= 1'b1;
    wf(2, 1'b1, 20);
    pins[3] <= 1'b0;
    xfer(1'b1, `EIC_IDX_TCC_HI, 8'h01);
    ack_all;
    pins[3] <= 1'b1;
    repeat (2) @(posedge hclk);
    pins[3] <= 1'b0;
    wf(2, 1'b0, 20);
    pins[3] <= 1'b1;
    wf(2, 1'b1, 20);
    xfer(1'b1, `EIC_IDX_TCC_HI, 8'h00);
    xfer(1'b1, `EIC_IDX_TCC_LO, 8'hc8);
    ack_all;
    pins[3] <= 1'b0;
    wf(2, 1'b0, 20);
    slow_run <= 1'b1;
    wf(2, 1'b1, 40);
    slow_run <= 1'b0;
    $display("test input c done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(flags, 3'h0);
    xfer(1'b0, `EIC_IDX_TCC_LO, 8'h00);
    check(rd, 32'h0);
    $display("test reset done");
    print_verdict;
  end
endmodule
bind eic_top eic_assertions #(.ADDR_W(ADDR_W)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_c(pin_c), .ack_a(ack_a),
  .ack_b(ack_b), .ack_c(ack_c), .request_flag_a(request_flag_a),
  .request_flag_b(request_flag_b), .request_flag_c(request_flag_c),
  .shared_pin_raw_level(shared_pin_raw_level));
